// *** src/twc_pkg.sv ***
// shared constants and types for the three-wire configuration port
package twc_pkg;

   // ---------------------------------------------------------------
   // register space
   // ---------------------------------------------------------------
   localparam int          NREG          = 23;
   localparam int          NWR           = 22;
   localparam int          OCT_W         = 8;
   localparam int          ADDR_W        = 7;
   localparam int          CNT_W         = 5;
   localparam logic [6:0]  WR_LAST_ADDR  = 7'h15;
   localparam logic [6:0]  RD_LAST_ADDR  = 7'h16;
   localparam int          LOAD_EN_BIT   = 0;
   localparam logic [7:0]  CFG_RST_VAL   = 8'h00;
   localparam logic [7:0]  RD_PAD_VAL    = 8'h00;
   localparam logic        RW_READ       = 1'b1;
   localparam logic        RW_WRITE      = 1'b0;
   localparam logic [2:0]  LAST_BIT      = 3'h7;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CORE_CLK_MHZ  = 20;
   localparam int          SCLK_HALF_NS  = 200;
   localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int          PH_W          = 3;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef logic [OCT_W-1:0]         twc_oct_t;
   typedef twc_oct_t [NWR-1:0]       twc_cfg_t;

endpackage

// *** src/twc_if.sv ***
// link wires between the host end and the device end
`timescale 1ns/1ps
interface twc_if;
   logic cs;
   logic sclk;
   logic io_h;
   logic io_h_oe;
   logic io_d;
   logic io_d_oe;
   wire  io;

   // shared data wire with a weak pull-up when nobody drives
   assign io = io_h_oe ? io_h : (io_d_oe ? io_d : 1'b1);

   modport host (output cs, output sclk, output io_h, output io_h_oe, input io);
   modport dev  (input cs, input sclk, input io, output io_d, output io_d_oe);
endinterface

// *** src/twc_dev.sv ***
// device end: shifts the link, keeps shadow and active configuration
`timescale 1ns/1ps
module twc_dev
   import twc_pkg::*;
(
   // core side
   input  wire logic          core_clk_i,
   input  wire logic          sys_rst_i,
   // link
   twc_if.dev                 lnk,
   // active configuration
   output twc_pkg::twc_cfg_t  cfg_o,
   output logic               load_o
);
   import twc_pkg::*;

   // ---------------------------------------------------------------
   // link domain, falling edges: sampling
   // ---------------------------------------------------------------
   logic [2:0]  bit_ff;
   logic        hdr_done_ff;
   logic [6:0]  shin_ff;
   logic [6:0]  addr_ff;
   logic        rw_ff;
   twc_cfg_t    shadow_ff;

   wire         oct_end  = (bit_ff == LAST_BIT);
   wire         hdr_end  = oct_end & ~hdr_done_ff;
   wire         data_end = oct_end & hdr_done_ff;
   wire         data_wr  = data_end & (rw_ff == RW_WRITE) & (addr_ff <= WR_LAST_ADDR);
   wire [7:0]   oct_in   = {shin_ff, lnk.io};

   // frame state is cleared by the strobe itself since the clock stops
   always_ff @(negedge lnk.sclk or negedge lnk.cs) begin
      if (!lnk.cs) begin
         bit_ff      <= 3'h0;
         hdr_done_ff <= 1'b0;
         shin_ff     <= 7'h00;
      end else begin
         bit_ff  <= bit_ff + 3'h1;
         shin_ff <= {shin_ff[5:0], lnk.io};
         if (hdr_end) begin
            hdr_done_ff <= 1'b1;
         end
      end
   end

   // address and direction survive the strobe so the core side can read rw
   always_ff @(negedge lnk.sclk or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_ff <= 7'h00;
         rw_ff   <= RW_WRITE;
      end else if (hdr_end) begin
         addr_ff <= shin_ff;
         rw_ff   <= lnk.io;
      end else if (data_end) begin
         addr_ff <= addr_ff + 7'h01;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NWR; g++) begin : g_shadow
         always_ff @(negedge lnk.sclk or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               shadow_ff[g] <= CFG_RST_VAL;
            end else if (data_wr && addr_ff == 7'(g)) begin
               shadow_ff[g] <= oct_in;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // link domain, rising edges: read-out
   // ---------------------------------------------------------------
   logic [2:0]  rd_bit_ff;
   logic [7:0]  rd_sh_ff;
   logic        oe_ff;

   wire         rd_act  = hdr_done_ff & (rw_ff == RW_READ);
   wire         rd_hit  = (addr_ff <= WR_LAST_ADDR);
   // shadow is only looked at here, a read never writes anything back
   wire [7:0]   rd_byte = rd_hit ? shadow_ff[addr_ff[4:0]] : RD_PAD_VAL;

   always_ff @(posedge lnk.sclk or negedge lnk.cs) begin
      if (!lnk.cs) begin
         rd_bit_ff <= 3'h0;
         rd_sh_ff  <= 8'h00;
         oe_ff     <= 1'b0;
      end else if (rd_act) begin
         oe_ff     <= 1'b1;
         rd_bit_ff <= rd_bit_ff + 3'h1;
         if (rd_bit_ff == 3'h0) begin
            rd_sh_ff <= rd_byte;
         end else begin
            rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
         end
      end
   end

   assign lnk.io_d    = rd_sh_ff[7];
   assign lnk.io_d_oe = oe_ff;

   // ---------------------------------------------------------------
   // core domain: commit on strobe release
   // ---------------------------------------------------------------
   logic        cs_s1_ff;
   logic        cs_s2_ff;
   logic        cs_s3_ff;
   logic        load_ff;
   twc_cfg_t    cfg_ff;

   wire         cs_fall = cs_s3_ff & ~cs_s2_ff;
   // shadow and rw are quiet while the strobe is low, so they are read directly
   wire         nxt_load = cs_fall & (rw_ff == RW_WRITE)
                           & shadow_ff[0][LOAD_EN_BIT];

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cs_s1_ff <= 1'b0;
         cs_s2_ff <= 1'b0;
         cs_s3_ff <= 1'b0;
         load_ff  <= 1'b0;
         cfg_ff   <= {NWR{CFG_RST_VAL}};
      end else begin
         cs_s1_ff <= lnk.cs;
         cs_s2_ff <= cs_s1_ff;
         cs_s3_ff <= cs_s2_ff;
         load_ff  <= nxt_load;
         if (nxt_load) begin
            cfg_ff <= shadow_ff;
         end
      end
   end

   assign cfg_o  = cfg_ff;
   assign load_o = load_ff;

endmodule // twc_dev

// *** src/twc_host.sv ***
// host end: frames read and write sequences and makes the serial clock
`timescale 1ns/1ps
module twc_host
   import twc_pkg::*;
(
   // clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   sys_rst_i,
   // link
   twc_if.host                         lnk,
   // request
   input  wire logic                   start_i,
   input  wire logic                   rw_i,
   input  wire logic [6:0]             addr_i,
   input  wire logic [4:0]             cnt_i,
   output logic                        busy_o,
   output logic                        done_o,
   // write data
   input  wire twc_pkg::twc_oct_t      wd_data_i,
   input  wire logic                   wd_valid_i,
   output logic                        wd_ready_o,
   // read data
   output twc_pkg::twc_oct_t           rd_data_o,
   output logic                        rd_valid_o
);
   import twc_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CSUP,
      ST_SHIFT,
      ST_TAIL
   } twc_hst_t;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   twc_hst_t    st_ff;
   logic [2:0]  ph_ff;
   logic        sclk_ff;
   logic        cs_ff;
   logic        io_ff;
   logic        oe_ff;
   logic [7:0]  tx_ff;
   logic [7:0]  rx_ff;
   logic [2:0]  bit_ff;
   logic [4:0]  oct_ff;
   logic        hdr_ff;
   logic        rw_ff;
   logic        need_ff;
   logic [7:0]  rd_data_ff;
   logic        rd_valid_ff;
   logic        done_ff;
   logic        io_s1_ff;
   logic        io_s2_ff;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire         in_shift = (st_ff == ST_SHIFT);
   wire         tick     = (ph_ff == PH_W'(SCLK_HALF_CYC - 1));
   wire         rise_ev  = in_shift & ~need_ff & tick & ~sclk_ff;
   wire         fall_ev  = in_shift & tick & sclk_ff;
   wire         last_bit = (bit_ff == LAST_BIT);
   wire         last_oct = (oct_ff == 5'h00);
   wire         is_read  = (rw_ff == RW_READ);
   wire         oct_done = fall_ev & last_bit;
   wire         hdr_done = oct_done & hdr_ff;
   wire         dat_done = oct_done & ~hdr_ff;
   wire         take_wd  = need_ff & wd_valid_i;
   wire [7:0]   rx_next  = {rx_ff[6:0], io_s2_ff};
   wire [4:0]   oct_init = (cnt_i == 5'h00) ? 5'h00 : cnt_i - 5'h01;
   wire         start_ok = (st_ff == ST_IDLE) & start_i;

   // ---------------------------------------------------------------
   // pin input synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         io_s1_ff <= 1'b1;
         io_s2_ff <= 1'b1;
      end else begin
         io_s1_ff <= lnk.io;
         io_s2_ff <= io_s1_ff;
      end
   end

   // ---------------------------------------------------------------
   // clock divider, stalls while a write byte is awaited
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || st_ff == ST_IDLE || need_ff || tick) begin
         ph_ff <= 3'h0;
      end else begin
         ph_ff <= ph_ff + 3'h1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sclk_ff <= 1'b0;
      end else if (rise_ev) begin
         sclk_ff <= 1'b1;
      end else if (fall_ev) begin
         sclk_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= ST_IDLE;
      end else begin
         unique case (st_ff)
            ST_IDLE: begin
               if (start_i) begin
                  st_ff <= ST_CSUP;
               end
            end
            ST_CSUP: begin
               if (tick) begin
                  st_ff <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (dat_done && last_oct) begin
                  st_ff <= ST_TAIL;
               end
            end
            ST_TAIL: begin
               if (tick) begin
                  st_ff <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // strobe frames each sequence; one group of rising addresses per frame
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cs_ff <= 1'b0;
         oe_ff <= 1'b1;
      end else if (start_ok) begin
         cs_ff <= 1'b1;
         oe_ff <= 1'b1;
      end else if (hdr_done && is_read) begin
         oe_ff <= 1'b0;
      end else if (st_ff == ST_TAIL && tick) begin
         cs_ff <= 1'b0;
         oe_ff <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // shifters and counters
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         tx_ff   <= 8'h00;
         io_ff   <= 1'b0;
         need_ff <= 1'b0;
      end else if (start_ok) begin
         tx_ff <= {addr_i, rw_i};
      end else if (take_wd) begin
         tx_ff   <= wd_data_i;
         need_ff <= 1'b0;
      end else if (rise_ev) begin
         io_ff <= tx_ff[7];
         tx_ff <= {tx_ff[6:0], 1'b0};
      end else if (oct_done && !is_read && !(dat_done && last_oct)) begin
         need_ff <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         bit_ff <= 3'h0;
         oct_ff <= 5'h00;
         hdr_ff <= 1'b0;
         rw_ff  <= RW_WRITE;
         rx_ff  <= 8'h00;
      end else if (start_ok) begin
         bit_ff <= 3'h0;
         oct_ff <= oct_init;
         hdr_ff <= 1'b1;
         rw_ff  <= rw_i;
      end else if (fall_ev) begin
         bit_ff <= bit_ff + 3'h1;
         rx_ff  <= rx_next;
         if (hdr_done) begin
            hdr_ff <= 1'b0;
         end else if (dat_done && !last_oct) begin
            oct_ff <= oct_ff - 5'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // answers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rd_data_ff  <= 8'h00;
         rd_valid_ff <= 1'b0;
         done_ff     <= 1'b0;
      end else begin
         rd_valid_ff <= dat_done & is_read;
         done_ff     <= (st_ff == ST_TAIL) & tick;
         if (dat_done && is_read) begin
            rd_data_ff <= rx_next;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign lnk.cs      = cs_ff;
   assign lnk.sclk    = sclk_ff;
   assign lnk.io_h    = io_ff;
   assign lnk.io_h_oe = oe_ff;
   assign busy_o      = (st_ff != ST_IDLE);
   assign done_o      = done_ff;
   assign wd_ready_o  = take_wd;
   assign rd_data_o   = rd_data_ff;
   assign rd_valid_o  = rd_valid_ff;

endmodule // twc_host

// *** testbench/twc_link_sva.sv ***
// link protocol assertions for the three-wire configuration port
`timescale 1ns/1ps
module twc_link_sva (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // link wires
   input wire logic cs,
   input wire logic sclk,
   input wire logic io_h,
   input wire logic io_h_oe,
   input wire logic io_d,
   input wire logic io_d_oe,
   input wire logic io
);
   // ---------------------------------------------------------------
   // bit counter within a frame
   // ---------------------------------------------------------------
   logic       sclk_ff;
   logic [2:0] bit_ff;
   logic [2:0] nxt_bit;
   wire        sclk_fall = sclk_ff & ~sclk;

   // plain edge detect so the counter needs no sampled-value function
   assign nxt_bit = !cs ? 3'h0 : (sclk_fall ? bit_ff + 3'h1 : bit_ff);
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sclk_ff <= 1'b0;
         bit_ff  <= 3'h0;
      end else begin
         sclk_ff <= sclk;
         bit_ff  <= nxt_bit;
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_high_phase;
      sclk [*4] ##1 !sclk;
   endsequence
   sequence s_cs_setup;
      !sclk [*4];
   endsequence
   sequence s_turn_wait;
      !sclk [*4] ##1 $rose(sclk);
   endsequence

   chk_sclk_idle_low: assert property (!cs |-> !sclk)
      else $error("serial clock moves outside a frame");
   chk_host_owns_idle: assert property (!cs |-> io_h_oe)
      else $error("host not driving data outside a frame");
   chk_no_bus_fight: assert property (!(io_h_oe && io_d_oe))
      else $error("both ends drive the data wire");
   chk_dev_quiet_idle: assert property (!cs |-> !io_d_oe)
      else $error("device drives data with strobe low");
   chk_host_hold_fall: assert property ($fell(sclk) && io_h_oe |-> $stable(io_h))
      else $error("host data moved at a falling clock edge");
   chk_dev_change_rise: assert property (io_d_oe && $changed(io_d) |-> $rose(sclk))
      else $error("device data moved away from a rising edge");
   chk_whole_octets: assert property ($fell(cs) |-> bit_ff == 3'h0)
      else $error("frame closed inside an octet");
   chk_strobe_setup: assert property ($rose(cs) |-> s_cs_setup)
      else $error("clock rose too soon after strobe");
   chk_sclk_high_time: assert property ($rose(sclk) |-> s_high_phase)
      else $error("serial clock high phase wrong");
   chk_dev_turn_rise: assert property ($rose(io_d_oe) |-> $rose(sclk) && !io_h_oe)
      else $error("device took the wire off a rising edge");
   chk_dev_takes_line: assert property ($fell(io_h_oe) |-> s_turn_wait ##0 (io_d_oe && io == io_d))
      else $error("device did not take the wire at the first rise");
   cov_read_turn: cover property ($rose(io_d_oe));
endmodule // twc_link_sva

// *** testbench/three_wire_config_port_tb_top.sv ***
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module three_wire_config_port_tb_top;
   import twc_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        core_clk_i;
   logic        sys_rst_i;
   logic        start_i;
   logic        rw_i;
   logic [6:0]  addr_i;
   logic [4:0]  cnt_i;
   logic        busy_o;
   logic        done_o;
   twc_oct_t    wd_data_i;
   logic        wd_valid_i;
   logic        wd_ready_o;
   twc_oct_t    rd_data_o;
   logic        rd_valid_o;
   twc_cfg_t    cfg_o;
   logic        load_o;
   int          miscompares;
   int          samples_checked;
   int          loads;
   int          wire_n;
   logic [15:0] wire_sr;
   twc_oct_t    shd [0:22];
   twc_oct_t    act [0:21];
   twc_oct_t    wq [$];
   twc_oct_t    rq [$];

   twc_if lk ();
   twc_host twc_host_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .lnk(lk.host),
      .start_i(start_i), .rw_i(rw_i), .addr_i(addr_i), .cnt_i(cnt_i), .busy_o(busy_o),
      .done_o(done_o), .wd_data_i(wd_data_i), .wd_valid_i(wd_valid_i),
      .wd_ready_o(wd_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
   twc_dev twc_dev_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .lnk(lk.dev),
      .cfg_o(cfg_o), .load_o(load_o));
   twc_link_sva twc_link_sva_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cs(lk.cs),
      .sclk(lk.sclk), .io_h(lk.io_h), .io_h_oe(lk.io_h_oe), .io_d(lk.io_d),
      .io_d_oe(lk.io_d_oe), .io(lk.io));

   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) if (load_o === 1'b1) loads++;
   // wire monitor keeps the first two octets of each frame
   always @(posedge lk.cs) wire_n = 0;
   always @(negedge lk.sclk) if (lk.cs === 1'b1 && wire_n < 16) begin
      wire_sr = {wire_sr[14:0], lk.io};
      wire_n++;
   end

   // ---------------------------------------------------------------
   // common tasks
   // ---------------------------------------------------------------
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic host_op(input logic rw, input logic [6:0] a, input int n);
      int   idx;
      int   k;
      logic tk;
      idx = 0;
      tk = 1'b0;
      rq.delete();
      @(negedge core_clk_i);
      start_i = 1'b1;
      rw_i = rw;
      addr_i = a;
      cnt_i = 5'(n);
      wd_valid_i = !rw;
      if (wq.size() > 0) wd_data_i = wq[0];
      for (k = 0; k < 4000; k++) begin
         @(negedge core_clk_i);
         start_i = 1'b0;
         if (k == 0) cmp({15'h0000, busy_o}, 16'h0001);
         if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
         if (done_o === 1'b1) break;
         if (tk) idx++;
         tk = (wd_ready_o === 1'b1);
         if (idx < wq.size()) wd_data_i = wq[idx];
      end
      if (k == 4000) miscompares++;
      cmp({15'h0000, busy_o}, 16'h0000);
      wd_valid_i = 1'b0;
      // strobe must rest low before the next frame; commit lands in here too
      repeat (8) @(negedge core_clk_i);
   endtask

   task automatic do_write(input logic [6:0] a, input int n);
      int   l0;
      int   i;
      logic ld;
      l0 = loads;
      host_op(RW_WRITE, a, n);
      cmp(wire_sr, {a, RW_WRITE, wq[0]});
      for (i = 0; i < n; i++) shd[a + i] = wq[i];
      ld = shd[0][LOAD_EN_BIT];
      cmp(16'(loads - l0), {15'h0000, ld});
      for (i = 0; i < NWR; i++) begin
         if (ld) act[i] = shd[i];
         cmp({8'h00, cfg_o[i]}, {8'h00, act[i]});
      end
   endtask

   task automatic do_read(input logic [6:0] a, input int n);
      int l0;
      int i;
      l0 = loads;
      host_op(RW_READ, a, n);
      cmp(wire_sr, {a, RW_READ, shd[a]});
      cmp(16'(rq.size()), 16'(n));
      for (i = 0; i < n; i++) cmp({8'h00, rq[i]}, {8'h00, shd[a + i]});
      cmp(16'(loads - l0), 16'h0000);
      for (i = 0; i < NWR; i++) cmp({8'h00, cfg_o[i]}, {8'h00, act[i]});
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_read;
      do_read(7'h00, 23);
   endtask

   task automatic t_write_all;
      wq.delete();
      for (int i = 0; i < NWR; i++) wq.push_back(8'(i * 37 + 1));
      do_write(7'h00, NWR);
      do_read(7'h00, NREG);
   endtask

   task automatic t_scattered;
      wq = {8'hA4};
      do_write(7'h00, 1);
      wq = {8'h5C, 8'h3E};
      do_write(7'h03, 2);
      do_read(7'h03, 2);
      wq = {8'hA5};
      do_write(7'h00, 1);
   endtask

   task automatic t_boundary;
      wq = {8'hC3};
      do_write(WR_LAST_ADDR, 1);
      do_read(7'h14, 3);
      do_read(RD_LAST_ADDR, 1);
      // a zero count still moves one octet
      host_op(RW_READ, 7'h02, 0);
      cmp(16'(rq.size()), 16'h0001);
      cmp({8'h00, rq[0]}, {8'h00, shd[2]});
   endtask

   initial begin
      sys_rst_i = 1'b1;
      start_i = 1'b0;
      rw_i = 1'b0;
      addr_i = 7'h00;
      cnt_i = 5'h00;
      wd_data_i = 8'h00;
      wd_valid_i = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      loads = 0;
      wire_n = 0;
      wire_sr = 16'h0000;
      for (int i = 0; i < NREG; i++) shd[i] = CFG_RST_VAL;
      for (int i = 0; i < NWR; i++) act[i] = CFG_RST_VAL;
      shd[22] = RD_PAD_VAL;
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      t_reset_read();
      t_write_all();
      t_scattered();
      t_boundary();
      test_done();
   end

   initial begin
      #2000000;
      miscompares++;
      test_done();
   end
endmodule // three_wire_config_port_tb_top
